// ==== rtl/power_wake_map.vh ====
// Behaviour
// - Soft-off short press powers on to working.
// - Working short press enters sleeping state.
// - Working hold over six seconds forces soft-off.
// - Sleeping short press wakes to working.
// - Sleeping hold over six seconds goes soft-off.
// - Software soft-off request switches system off.
// - Listed wake sources wake from S3, S4, S5.
// - USB wakes only from S3.
// - Front-panel switch requests power and sleep.
// - PCI power-event wakes only when enabled.
// - AC return restores last state per policy.
// - Rail fault forces power-down and warning.
`ifndef POWER_WAKE_MAP_VH
`define POWER_WAKE_MAP_VH
`define CLK_HZ          10000000
`define SHORT_PRESS_S   4
`define LONG_PRESS_S    6
`define DEBOUNCE_US     10000
`define ST_S0           3'h0
`define ST_S3           3'h1
`define ST_S4           3'h2
`define ST_S5           3'h3
`define POLICY_OFF      2'h0
`define POLICY_ON       2'h1
`define POLICY_LAST     2'h2
`endif

// ==== rtl/power_button_wake_controller.v ====
`timescale 1ns/1ps
`include "power_wake_map.vh"
module power_button_wake_controller #(
  parameter [31:0] SHORT_CYCLES    = `SHORT_PRESS_S * `CLK_HZ,
  parameter [31:0] LONG_CYCLES     = `LONG_PRESS_S * `CLK_HZ,
  parameter [31:0] DEBOUNCE_CYCLES = (`DEBOUNCE_US * (`CLK_HZ / 1000000))
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       power_switch_n,
  input  wire       rtc_alarm,
  input  wire       lan_wake,
  input  wire       usb_wake,
  input  wire       pci_event_wake,
  input  wire       pcie_wake,
  input  wire       infrared_remote_wake,
  input  wire       pci_event_wake_en,
  input  wire       os_soft_off,
  input  wire       os_sleep_s3,
  input  wire       os_sleep_s4,
  input  wire       rail_fault,
  input  wire [1:0] ac_policy,
  input  wire       last_state_on,
  output reg        power_on,
  output reg  [2:0] sleep_state,
  output reg        rail_warning
);

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [2:0]  sw_sync_r;
  reg  [2:0]  wk_a_r;
  reg  [2:0]  wk_b_r;
  reg  [2:0]  wk_c_r;
  reg  [2:0]  wk_d_r;
  reg  [2:0]  wk_e_r;
  reg  [2:0]  wk_f_r;
  reg  [2:0]  fault_r;
  reg  [31:0] db_cnt_r;
  reg         pressed_r;
  reg  [31:0] hold_cnt_r;
  reg         long_done_r;
  reg         boot_done_r;
  wire        sw_level;
  wire        press_release;
  wire        long_hit;
  wire        wake_any;
  wire        wake_deep;
  reg         sw_lvl_r;
  reg         rtc_lvl_r;
  reg         lan_lvl_r;
  reg         usb_lvl_r;
  reg         pci_lvl_r;
  reg         pcie_lvl_r;
  reg         ir_lvl_r;
  reg         fault_lvl_r;
  wire        rtc_lvl;
  wire        lan_lvl;
  wire        usb_lvl;
  wire        pci_lvl;
  wire        pcie_lvl;
  wire        ir_lvl;
  wire        fault_lvl;

  // A synchronised level changes only once the last two stages agree.
  function filt;
    input [2:0] s;
    input       held;
    begin
      if (s[2] == s[1]) begin
        filt = s[2];
      end else begin
        filt = held;
      end
    end
  endfunction

  always @(posedge clk) begin
    sw_sync_r <= {sw_sync_r[1:0], ~power_switch_n};
    wk_a_r    <= {wk_a_r[1:0], rtc_alarm};
    wk_b_r    <= {wk_b_r[1:0], lan_wake};
    wk_c_r    <= {wk_c_r[1:0], usb_wake};
    wk_d_r    <= {wk_d_r[1:0], pci_event_wake};
    wk_e_r    <= {wk_e_r[1:0], pcie_wake};
    wk_f_r    <= {wk_f_r[1:0], infrared_remote_wake};
    fault_r   <= {fault_r[1:0], rail_fault};
  end

  assign sw_level  = filt(sw_sync_r, sw_lvl_r);
  assign rtc_lvl   = filt(wk_a_r, rtc_lvl_r);
  assign lan_lvl   = filt(wk_b_r, lan_lvl_r);
  assign usb_lvl   = filt(wk_c_r, usb_lvl_r);
  assign pci_lvl   = filt(wk_d_r, pci_lvl_r);
  assign pcie_lvl  = filt(wk_e_r, pcie_lvl_r);
  assign ir_lvl    = filt(wk_f_r, ir_lvl_r);
  assign fault_lvl = filt(fault_r, fault_lvl_r);

  always @(posedge clk) begin
    if (reset) begin
      sw_lvl_r    <= 1'h0;
      rtc_lvl_r   <= 1'h0;
      lan_lvl_r   <= 1'h0;
      usb_lvl_r   <= 1'h0;
      pci_lvl_r   <= 1'h0;
      pcie_lvl_r  <= 1'h0;
      ir_lvl_r    <= 1'h0;
      fault_lvl_r <= 1'h0;
    end else begin
      sw_lvl_r    <= sw_level;
      rtc_lvl_r   <= rtc_lvl;
      lan_lvl_r   <= lan_lvl;
      usb_lvl_r   <= usb_lvl;
      pci_lvl_r   <= pci_lvl;
      pcie_lvl_r  <= pcie_lvl;
      ir_lvl_r    <= ir_lvl;
      fault_lvl_r <= fault_lvl;
    end
  end

  // Debounced press state and hold timer.
  always @(posedge clk) begin
    if (reset) begin
      db_cnt_r    <= 32'h00000000;
      pressed_r   <= 1'b0;
      hold_cnt_r  <= 32'h00000000;
      long_done_r <= 1'b0;
    end else begin
      if (sw_level == pressed_r) begin
        db_cnt_r <= 32'h00000000;
      end else if (db_cnt_r >= DEBOUNCE_CYCLES) begin
        db_cnt_r  <= 32'h00000000;
        pressed_r <= sw_level;
      end else begin
        db_cnt_r <= db_cnt_r + 32'h00000001;
      end
      if (!pressed_r) begin
        hold_cnt_r  <= 32'h00000000;
        long_done_r <= 1'b0;
      end else begin
        if (hold_cnt_r != 32'hFFFFFFFF) begin
          hold_cnt_r <= hold_cnt_r + 32'h00000001;
        end
        if (long_hit) begin
          long_done_r <= 1'b1;
        end
      end
    end
  end

  // A release before the long threshold counts as a short press.
  assign press_release = pressed_r && db_cnt_r >= DEBOUNCE_CYCLES && !sw_level
                         && !long_done_r && hold_cnt_r < LONG_CYCLES;
  assign long_hit      = pressed_r && !long_done_r && hold_cnt_r >= LONG_CYCLES;

  assign wake_deep = rtc_lvl | lan_lvl | pcie_lvl | ir_lvl
                     | (pci_lvl & pci_event_wake_en);
  assign wake_any  = wake_deep | usb_lvl;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_S0: begin
        if (long_hit) begin
          state_nxt = `ST_S5;
        end else if (press_release) begin
          state_nxt = `ST_S3;
        end else if (os_soft_off) begin
          state_nxt = `ST_S5;
        end else if (os_sleep_s4) begin
          state_nxt = `ST_S4;
        end else if (os_sleep_s3) begin
          state_nxt = `ST_S3;
        end
      end
      `ST_S3: begin
        if (long_hit) begin
          state_nxt = `ST_S5;
        end else if (press_release || wake_any) begin
          state_nxt = `ST_S0;
        end
      end
      `ST_S4: begin
        if (long_hit) begin
          state_nxt = `ST_S5;
        end else if (press_release || wake_deep) begin
          state_nxt = `ST_S0;
        end
      end
      default: begin
        if (press_release || wake_deep) begin
          state_nxt = `ST_S0;
        end
      end
    endcase
    if (fault_lvl) begin
      state_nxt = `ST_S5;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_r      <= `ST_S5;
      boot_done_r  <= 1'b0;
      rail_warning <= 1'b0;
      power_on     <= 1'b0;
      sleep_state  <= `ST_S5;
    end else begin
      boot_done_r <= 1'b1;
      if (!boot_done_r) begin
        if (fault_lvl) begin
          state_r <= `ST_S5;
        end else if (ac_policy == `POLICY_ON
            || (ac_policy == `POLICY_LAST && last_state_on)) begin
          state_r <= `ST_S0;
        end else begin
          state_r <= `ST_S5;
        end
      end else begin
        state_r <= state_nxt;
      end
      if (fault_lvl) begin
        rail_warning <= 1'b1;
      end
      power_on    <= (state_r == `ST_S0);
      sleep_state <= state_r;
    end
  end

endmodule

// ==== tb/pbw_monitor.sv ====
`timescale 1ns/1ps
module pbw_monitor (
  input wire       clk,
  input wire       reset,
  input wire       os_soft_off,
  input wire       os_sleep_s3,
  input wire       os_sleep_s4,
  input wire       rail_fault,
  input wire       power_on,
  input wire [2:0] sleep_state,
  input wire       rail_warning
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_on_s0: assert property (power_on == (sleep_state == 3'h0))
    else $error("power_on disagrees with sleep_state");
  a_state_ok: assert property (sleep_state <= 3'h3)
    else $error("sleep_state outside the known codes");
  a_fault_off: assert property (rail_fault [*7] |-> !power_on)
    else $error("power stayed on during a rail fault");
  a_warn_set: assert property (rail_fault [*7] |-> rail_warning)
    else $error("rail_warning missing during a rail fault");
  a_warn_hold: assert property (rail_warning |=> rail_warning)
    else $error("rail_warning cleared without reset");
  a_off_cmd: assert property (os_soft_off ##1 power_on
    |-> ##[1:2] sleep_state == 3'h3) else $error("soft-off request not obeyed");
  a_s3_cmd: assert property ((!os_soft_off && !os_sleep_s4 && os_sleep_s3)
    ##1 power_on |-> ##[1:2] sleep_state == 3'h1) else $error("sleep request not obeyed");
  a_s4_cmd: assert property ((!os_soft_off && os_sleep_s4) ##1 power_on
    |-> ##[1:2] sleep_state == 3'h2) else $error("deep sleep request not obeyed");
  a_s5_exit: assert property (sleep_state == 3'h3
    |=> sleep_state == 3'h3 || sleep_state == 3'h0) else $error("soft-off left to a sleep state");
  a_s4_exit: assert property (sleep_state == 3'h2 |=> sleep_state != 3'h1)
    else $error("deep sleep left to light sleep");
endmodule
bind power_button_wake_controller pbw_monitor pbw_monitor_i (.clk, .reset, .os_soft_off,
  .os_sleep_s3, .os_sleep_s4, .rail_fault, .power_on, .sleep_state, .rail_warning);

// ==== tb/switch_model.sv ====
`timescale 1ns/1ps
module switch_model (
  input  wire clk,
  output reg  power_switch_n
);
  initial power_switch_n = 1'b1;
  task press(input integer n);
    begin
      @(posedge clk);
      #10 power_switch_n = 1'b0;
      repeat (n) @(posedge clk);
      #10 power_switch_n = 1'b1;
    end
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  reg        clk = 0, reset = 1, wen = 0, last_on = 1;
  reg  [1:0] pol = 2'h2;
  reg  [9:0] ev = 10'h000;
  wire       sw_n, on, warn;
  wire [2:0] st;
  integer    failures = 0, tests_run = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end
  switch_model sw_i (.clk(clk), .power_switch_n(sw_n));
  power_button_wake_controller #(.SHORT_CYCLES(32'h64), .LONG_CYCLES(32'hC8),
    .DEBOUNCE_CYCLES(32'h4)) power_button_wake_controller_i (.clk(clk), .reset(reset),
    .power_switch_n(sw_n), .rtc_alarm(ev[0]), .lan_wake(ev[1]), .usb_wake(ev[2]),
    .pci_event_wake(ev[3]), .pcie_wake(ev[4]), .infrared_remote_wake(ev[5]),
    .pci_event_wake_en(wen), .os_soft_off(ev[6]), .os_sleep_s3(ev[7]), .os_sleep_s4(ev[8]),
    .rail_fault(ev[9]), .ac_policy(pol), .last_state_on(last_on), .power_on(on),
    .sleep_state(st), .rail_warning(warn));
  task step(input integer i, input integer n, input [3:0] exp);
    begin
      @(posedge clk);
      if (i == 10)
        sw_i.press(n);
      else if (i < 10) begin
        #10 ev = 10'h001 << i;
        repeat (n) @(posedge clk);
        #10 ev = 10'h000;
      end
      repeat (20) @(posedge clk);
      #10;
      tests_run = tests_run + 1;
      if ({warn, st} !== exp || on !== (exp == 4'h0)) begin
        failures = failures + 1;
        $display("unexpected state: expected %h, seen %b%h on %b", exp, warn, st, on);
      end
    end
  endtask
  task do_reset(input [1:0] p, input l, input [3:0] exp);
    begin
      @(posedge clk);
      #10 reset = 1'b1;
      pol = p;
      last_on = l;
      repeat (4) @(posedge clk);
      #10 reset = 1'b0;
      @(posedge clk);
      #10;
      tests_run = tests_run + 1;
      if (st !== 3'h3 || on !== 1'b0 || warn !== 1'b0) begin
        failures = failures + 1;
        $display("unexpected reset state: expected 03, seen %b%h", warn, st);
      end
      step(11, 1, exp);
    end
  endtask
  task t_policy;
    begin
      do_reset(2'h0, 1'b1, 4'h3);
      do_reset(2'h1, 1'b0, 4'h0);
      do_reset(2'h2, 1'b0, 4'h3);
      do_reset(2'h2, 1'b1, 4'h0);
      $display("done: policy");
    end
  endtask
  task t_switch;
    begin
      step(10, 50, 4'h1);
      step(10, 50, 4'h0);
      step(10, 250, 4'h3);
      step(10, 150, 4'h0);
      step(10, 150, 4'h1);
      step(10, 50, 4'h0);
      step(7, 1, 4'h1);
      step(10, 250, 4'h3);
      $display("done: switch");
    end
  endtask
  task t_wake;
    integer i;
    begin
      step(2, 10, 4'h3);
      step(3, 10, 4'h3);
      #10 wen = 1'b1;
      for (i = 0; i < 6; i = i + 1)
        if (i != 2) begin
          step(i, 10, 4'h0);
          step(8, 1, 4'h2);
        end
      step(2, 10, 4'h2);
      step(0, 10, 4'h0);
      step(7, 1, 4'h1);
      step(2, 10, 4'h0);
      step(6, 1, 4'h3);
      step(0, 10, 4'h0);
      step(9, 10, 4'hB);
      $display("done: wake");
    end
  endtask
  task report_and_stop;
    begin
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #10 reset = 0;
    step(11, 1, 4'h0);
    t_switch;
    t_wake;
    t_policy;
    report_and_stop;
  end
endmodule
